// File: hdl/mid_core.sv
/*
  instruction decode and execute core: fetches 14-bit words, decodes them,
  drives accumulator, flags, fetch pointer, register file, stack and timer.
  assumes program memory and register file answer combinationally in the
  same clock, and an outside stack whose head is readable at any time.
  one instruction cycle is two clocks: fetch, then execute.
*/
// Added by the designer: the placing of the registers and the strobed register port.
// Function
// RULE_01: each word is 14 bits: opcode part plus operand fields.
// RULE_02: destination bit 0 sends result to accumulator, 1 to register.
// RULE_03: add accumulator to register, one cycle, updates C, DC, Z.
// RULE_04: subtract accumulator from register, one cycle, updates C, DC, Z.
// RULE_05: and, or, xor with register take one cycle, update only Z.
// RULE_06: register clear and accumulator clear write zero, update Z.
// RULE_07: invert, decrement, increment honour destination, update only Z.
// RULE_08: decrement or increment with skip on zero result, no flags.
// RULE_09: copy register to accumulator or back, one cycle, no flags.
// RULE_10: store accumulator to second plane by 6-bit address, no flags.
// RULE_11: rotate left or right through carry; only carry changes.
// RULE_12: nibble exchange honours destination, changes no flags.
// RULE_13: register null test sets Z when register holds zero.
// RULE_14: bit clear or set of 6-bit addressed register, no flags.
// RULE_15: bit tests skip next on clear or set, no flags.
// RULE_16: add 8-bit literal to accumulator, updates C, DC, Z.
// RULE_17: and, or, xor literal into accumulator update only Z.
// RULE_18: load literal into accumulator, flags unchanged.
// RULE_19: call and jump carry 10-bit target, take two cycles.
// RULE_20: returns take two cycles; return with literal loads accumulator.
// RULE_21: all-zero word idles; dog timer clear resets timers, sets TO, PD.
// RULE_22: standby word stops clock and updates TO, PD.
// RULE_23: call pushes next address before loading 10-bit target.
// RULE_24: taken skip turns fetched next word into a no-operation.
// RULE_25: clearing register or accumulator always sets zero flag.
// RULE_26: unknown patterns execute as one-cycle no-operation.
`timescale 1ns/10ps

module mid_core
  import mid_pkg::*;
#(
  parameter int unsigned PTR_W = 10
)(
  input  wire logic               mclk_in,
  input  wire logic               arst_n_in,
  input  wire logic [13:0]        instr_in,
  output logic                    fetch_out,
  output logic [PTR_W-1:0]        fetch_pointer_out,
  output logic [6:0]              rf_addr_out,
  output logic                    rf_rplane_out,
  input  wire logic [7:0]         rf_rdata_in,
  output logic                    rf_wr_out,
  output logic [7:0]              rf_wdata_out,
  output logic                    stack_push_out,
  output logic                    stack_pop_out,
  output logic [PTR_W-1:0]        stack_push_data_out,
  input  wire logic [PTR_W-1:0]   stack_head_in,
  output logic                    dog_clear_out,
  output logic                    gie_set_out,
  output logic                    standby_out,
  input  wire logic               wake_in,
  output logic                    instr_done_out,
  output logic [1:0]              instr_cycles_out,
  input  wire logic [2:0]         reg_addr_in,
  input  wire logic [7:0]         reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic [7:0]              reg_rdata_out
);

  initial
  begin
    if (PTR_W < TGT_W || PTR_W > 16)
      $error("fetch pointer width must be 10 to 16");
  end

  // RULE_01 split word
  // map a 14-bit word onto its operation; exact words first
  function automatic mid_op_t mid_decode(input logic [13:0] w);
    mid_op_t op;
    op = OP_NOP;
    if (w == W_SLEEP) op = OP_SLEEP;
    else if (w == W_DOGCLR) op = OP_DOGCLR;
    else if (w == W_RET) op = OP_RET;
    else if (w == W_INTERRUPT_EXIT) op = OP_INTERRUPT_EXIT;
    else if (w == W_CLRACC) op = OP_CLEAR_ACC;
    else if (w == W_NOP) op = OP_NOP;
    else if (w[13:7] == P_STORE) op = OP_STORE;
    else if (w[13:6] == 8'h00) op = OP_STORER;
    else if (w[13:7] == P_CLEAR_REG) op = OP_CLEAR_REG;
    else if (w[13:7] == P_LOAD) op = OP_LOAD;
    else if (w[13:7] == P_REG_NULL_TEST) op = OP_REG_NULL_TEST;
    else if (w[13:9] == P_BCLR) op = OP_BCLR;
    else if (w[13:9] == P_BSET) op = OP_BSET;
    else if (w[13:9] == P_BTSC) op = OP_BTSC;
    else if (w[13:9] == P_BTSS) op = OP_BTSS;
    else if (w[13:10] == P_CALL) op = OP_CALL;
    else if (w[13:10] == P_JUMP) op = OP_JUMP;
    else
    begin
      // RULE_26 unknown is idle
      case (w[13:8])
        P_ADD:  op = OP_ADD;
        P_SUB:  op = OP_SUB;
        P_AND:  op = OP_AND;
        P_OR:   op = OP_OR;
        P_XOR:  op = OP_XOR;
        P_COM:  op = OP_COM;
        P_DEC:  op = OP_DEC;
        P_INC:  op = OP_INC;
        P_DECS: op = OP_DECS;
        P_INCS: op = OP_INCS;
        P_RLC:  op = OP_RLC;
        P_RRC:  op = OP_RRC;
        P_SWAP: op = OP_SWAP;
        P_ADDL: op = OP_ADDL;
        P_ANDL: op = OP_ANDL;
        P_ORL:  op = OP_ORL;
        P_XORL: op = OP_XORL;
        P_LDL:  op = OP_LDL;
        P_RETL: op = OP_RETL;
        default: op = OP_NOP;
      endcase
    end
    return op;
  endfunction

  mid_state_t         st_ff;
  mid_state_t         nxt_st;
  logic [13:0]        instr_ff;
  logic               skip_ff;
  logic               squash_ff;
  logic [PTR_W-1:0]   pc_ff;
  logic [7:0]         acc_ff;
  logic [4:0]         status_ff;
  mid_op_t            fetch_op;
  mid_op_t            exec_op;
  logic [7:0]         res;
  logic [7:0]         bit_mask;
  logic [8:0]         sum9;
  logic [4:0]         half5;
  logic               wr_acc;
  logic               wr_rf;
  logic               do_skip;
  logic               two_cyc;
  logic [7:0]         nxt_acc;
  logic [4:0]         nxt_status;
  logic               exec_fire;

  assign fetch_op  = mid_decode(instr_in);
  assign exec_op   = squash_ff ? OP_NOP : mid_decode(instr_ff);
  assign exec_fire = (st_ff == ST_EXEC);
  assign fetch_out = (st_ff == ST_FETCH);
  assign fetch_pointer_out = pc_ff;
  assign bit_mask  = 8'h01 << instr_ff[8:6];

  // execute datapath: result, destination and flag effects
  always_comb
  begin
    res        = rf_rdata_in;
    wr_acc     = 1'b0;
    wr_rf      = 1'b0;
    do_skip    = 1'b0;
    two_cyc    = 1'b0;
    sum9       = 9'h000;
    half5      = 5'h00;
    nxt_status = status_ff;
    unique case (exec_op)
      // RULE_03 add with flags
      // RULE_16 literal add shared
      OP_ADD, OP_ADDL:
      begin
        sum9  = {1'b0, (exec_op == OP_ADDL) ? instr_ff[7:0] : rf_rdata_in} + {1'b0, acc_ff};
        half5 = {1'b0, (exec_op == OP_ADDL) ? instr_ff[3:0] : rf_rdata_in[3:0]}
              + {1'b0, acc_ff[3:0]};
        res   = sum9[7:0];
        nxt_status[FLAG_C]  = sum9[8];
        nxt_status[FLAG_DC] = half5[4];
        nxt_status[FLAG_Z]  = (res == 8'h00);
      end
      // RULE_04 subtract, carry means no borrow
      OP_SUB:
      begin
        res = rf_rdata_in - acc_ff;
        nxt_status[FLAG_C]  = (rf_rdata_in >= acc_ff);
        nxt_status[FLAG_DC] = (rf_rdata_in[3:0] >= acc_ff[3:0]);
        nxt_status[FLAG_Z]  = (res == 8'h00);
      end
      // RULE_05 logic with register
      OP_AND:  res = rf_rdata_in & acc_ff;
      OP_OR:   res = rf_rdata_in | acc_ff;
      OP_XOR:  res = rf_rdata_in ^ acc_ff;
      // RULE_07 unary byte operations
      OP_COM:  res = ~rf_rdata_in;
      OP_DEC:  res = rf_rdata_in - 8'h01;
      OP_INC:  res = rf_rdata_in + 8'h01;
      // RULE_08 skip on zero result
      OP_DECS:
      begin
        res     = rf_rdata_in - 8'h01;
        do_skip = (res == 8'h00);
      end
      OP_INCS:
      begin
        res     = rf_rdata_in + 8'h01;
        do_skip = (res == 8'h00);
      end
      // RULE_06 clear target
      OP_CLEAR_REG, OP_CLEAR_ACC: res = 8'h00;
      // RULE_09 moves
      OP_LOAD: res = rf_rdata_in;
      // RULE_09 store back and RULE_10 second plane store
      OP_STORE, OP_STORER: res = acc_ff;
      // RULE_11 rotate through carry
      OP_RLC:
      begin
        res = {rf_rdata_in[6:0], status_ff[FLAG_C]};
        nxt_status[FLAG_C] = rf_rdata_in[7];
      end
      OP_RRC:
      begin
        res = {status_ff[FLAG_C], rf_rdata_in[7:1]};
        nxt_status[FLAG_C] = rf_rdata_in[0];
      end
      // RULE_12 nibble exchange
      OP_SWAP: res = {rf_rdata_in[3:0], rf_rdata_in[7:4]};
      // RULE_13 null test
      OP_REG_NULL_TEST: nxt_status[FLAG_Z] = (rf_rdata_in == 8'h00);
      // RULE_14 bit force
      OP_BCLR: res = rf_rdata_in & ~bit_mask;
      OP_BSET: res = rf_rdata_in | bit_mask;
      // RULE_15 bit tests
      OP_BTSC: do_skip = ((rf_rdata_in & bit_mask) == 8'h00);
      OP_BTSS: do_skip = ((rf_rdata_in & bit_mask) != 8'h00);
      // RULE_17 literal logic
      OP_ANDL: res = instr_ff[7:0] & acc_ff;
      OP_ORL:  res = instr_ff[7:0] | acc_ff;
      OP_XORL: res = instr_ff[7:0] ^ acc_ff;
      // RULE_18 literal load
      OP_LDL:  res = instr_ff[7:0];
      // RULE_20 return with literal
      OP_RETL:
      begin
        res     = instr_ff[7:0];
        two_cyc = 1'b1;
      end
      // RULE_19 branches take two cycles
      OP_CALL, OP_JUMP, OP_RET, OP_INTERRUPT_EXIT: two_cyc = 1'b1;
      // RULE_21 dog timer clear marks awake
      OP_DOGCLR:
      begin
        nxt_status[FLAG_TO] = 1'b1;
        nxt_status[FLAG_PD] = 1'b1;
      end
      // RULE_22 standby entry
      OP_SLEEP:
      begin
        nxt_status[FLAG_TO] = 1'b1;
        nxt_status[FLAG_PD] = 1'b0;
      end
      OP_NOP: res = rf_rdata_in;
    endcase
    // RULE_02 destination routing
    unique case (exec_op)
      OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_COM, OP_DEC, OP_INC, OP_DECS,
      OP_INCS, OP_RLC, OP_RRC, OP_SWAP:
      begin
        wr_rf  = instr_ff[7];
        wr_acc = ~instr_ff[7];
      end
      OP_CLEAR_REG, OP_STORE, OP_STORER, OP_BCLR, OP_BSET: wr_rf = 1'b1;
      OP_CLEAR_ACC, OP_LOAD, OP_ADDL, OP_ANDL, OP_ORL, OP_XORL, OP_LDL, OP_RETL:
        wr_acc = 1'b1;
      default:
      begin
        wr_rf  = 1'b0;
        wr_acc = 1'b0;
      end
    endcase
    // RULE_05 zero flag of logic and unary operations
    if (exec_op inside {OP_AND, OP_OR, OP_XOR, OP_COM, OP_DEC, OP_INC, OP_ANDL,
                        OP_ORL, OP_XORL})
      nxt_status[FLAG_Z] = (res == 8'h00);
    // RULE_25 clear always sets zero
    if (exec_op inside {OP_CLEAR_REG, OP_CLEAR_ACC})
      nxt_status[FLAG_Z] = 1'b1;
    nxt_acc = wr_acc ? res : acc_ff;
  end

  // sequencer: fetch, execute, dead cycle for branches, standby
  always_comb
  begin
    nxt_st = st_ff;
    unique case (st_ff)
      ST_FETCH: nxt_st = ST_EXEC;
      ST_EXEC:
        if (exec_op == OP_SLEEP) nxt_st = ST_SLEEP;
        else if (two_cyc) nxt_st = ST_DUMA;
        else nxt_st = ST_FETCH;
      ST_DUMA:  nxt_st = ST_DUMB;
      ST_DUMB:  nxt_st = ST_FETCH;
      ST_SLEEP: nxt_st = wake_in ? ST_FETCH : ST_SLEEP;
      default:  nxt_st = ST_FETCH;
    endcase
  end

  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) st_ff <= ST_FETCH;
    else st_ff <= nxt_st;
  end

  // latch word and register-file address at fetch
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      instr_ff      <= W_NOP;
      squash_ff     <= 1'b0;
      rf_addr_out   <= 7'h00;
      rf_rplane_out <= 1'b0;
    end
    else if (st_ff == ST_FETCH)
    begin
      instr_ff  <= instr_in;
      // RULE_24 skipped word becomes idle
      squash_ff <= skip_ff;
      rf_rplane_out <= (fetch_op == OP_STORER);
      if (fetch_op inside {OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS, OP_STORER})
        rf_addr_out <= {1'b0, instr_in[5:0]};
      else
        rf_addr_out <= instr_in[6:0];
    end
  end

  // skip request carried to the next fetch
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) skip_ff <= 1'b0;
    else if (exec_fire) skip_ff <= do_skip;
    else if (st_ff == ST_FETCH) skip_ff <= 1'b0;
  end

  // fetch pointer: advance at fetch, load target or stack head at execute
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) pc_ff <= '0;
    else if (st_ff == ST_FETCH) pc_ff <= pc_ff + 1'b1;
    else if (exec_fire && exec_op inside {OP_CALL, OP_JUMP})
      pc_ff[TGT_W-1:0] <= instr_ff[TGT_W-1:0];
    else if (exec_fire && exec_op inside {OP_RET, OP_INTERRUPT_EXIT, OP_RETL})
      pc_ff <= stack_head_in;
  end

  // accumulator and status; execute wins over a register-port write
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      acc_ff    <= ACC_RST;
      status_ff <= STATUS_RST;
    end
    else if (exec_fire)
    begin
      acc_ff    <= nxt_acc;
      status_ff <= nxt_status;
    end
    else if (reg_wr_in && reg_addr_in == REG_ACC) acc_ff <= reg_wdata_in;
    else if (reg_wr_in && reg_addr_in == REG_STATUS) status_ff <= reg_wdata_in[4:0];
  end

  // register-file write, stack and side pulses, one clock each
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rf_wr_out           <= 1'b0;
      rf_wdata_out        <= 8'h00;
      stack_push_out      <= 1'b0;
      stack_pop_out       <= 1'b0;
      stack_push_data_out <= '0;
      dog_clear_out       <= 1'b0;
      gie_set_out         <= 1'b0;
      instr_done_out      <= 1'b0;
      instr_cycles_out    <= 2'h0;
    end
    else
    begin
      rf_wr_out      <= exec_fire && wr_rf;
      stack_push_out <= exec_fire && (exec_op == OP_CALL);
      stack_pop_out  <= exec_fire && (exec_op inside {OP_RET, OP_INTERRUPT_EXIT, OP_RETL});
      dog_clear_out  <= exec_fire && (exec_op == OP_DOGCLR);
      gie_set_out    <= exec_fire && (exec_op == OP_INTERRUPT_EXIT);
      instr_done_out <= exec_fire && !squash_ff;
      if (exec_fire)
      begin
        rf_wdata_out <= res;
        instr_cycles_out <= (two_cyc || do_skip) ? 2'h2 : 2'h1;
      end
      // RULE_23 push next address
      if (exec_fire && exec_op == OP_CALL) stack_push_data_out <= pc_ff;
    end
  end

  // standby level until wake
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) standby_out <= 1'b0;
    else standby_out <= (nxt_st == ST_SLEEP);
  end

  // register port read, data one clock later
  always_ff @(posedge mclk_in or negedge arst_n_in)
  begin
    if (!arst_n_in) reg_rdata_out <= 8'h00;
    else if (reg_rd_in)
      unique case (reg_addr_in)
        REG_STATUS: reg_rdata_out <= {3'h0, status_ff};
        REG_ACC:    reg_rdata_out <= acc_ff;
        REG_PTR_LO: reg_rdata_out <= pc_ff[7:0];
        REG_PTR_HI: reg_rdata_out <= 8'(pc_ff >> 8);
        default:    reg_rdata_out <= 8'h00;
      endcase
    else reg_rdata_out <= 8'h00;
  end

  dest_acc_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_02
    exec_fire && exec_op == OP_ADD && !instr_ff[7] |=> !rf_wr_out)
    else $error("add with destination 0 wrote the register file");
  add_result_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_03
    exec_fire && exec_op == OP_ADD && instr_ff[7]
    |=> rf_wr_out && rf_wdata_out == 8'($past(rf_rdata_in) + $past(acc_ff)))
    else $error("add result wrong");
  clear_zero_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_25
    exec_fire && exec_op inside {OP_CLEAR_REG, OP_CLEAR_ACC} |=> status_ff[FLAG_Z])
    else $error("clear left zero flag low");
  branch_two_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_19
    exec_fire && exec_op == OP_JUMP |=> st_ff == ST_DUMA ##1 st_ff == ST_DUMB
    ##1 st_ff == ST_FETCH)
    else $error("jump did not take two cycles");
  call_push_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_23
    exec_fire && exec_op == OP_CALL |=> stack_push_out
    && stack_push_data_out == $past(pc_ff)
    && pc_ff[TGT_W-1:0] == $past(instr_ff[TGT_W-1:0]))
    else $error("call push or target wrong");
  skip_idle_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_24
    st_ff == ST_FETCH && skip_ff |=> ##1 !rf_wr_out && !stack_push_out
    && acc_ff == $past(acc_ff))
    else $error("skipped word had an effect");
  move_flags_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_09
    exec_fire && exec_op == OP_LOAD |=> status_ff == $past(status_ff)
    && acc_ff == $past(rf_rdata_in))
    else $error("register load changed flags or missed");
  rotate_carry_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_11
    exec_fire && exec_op == OP_RLC |=> status_ff[FLAG_C] == $past(rf_rdata_in[7])
    && status_ff[FLAG_Z] == $past(status_ff[FLAG_Z]))
    else $error("rotate carry wrong");
  lit_load_a: assert property (@(posedge mclk_in) disable iff (!arst_n_in) // RULE_18
    exec_fire && exec_op == OP_LDL |=> acc_ff == $past(instr_ff[7:0])
    && $stable(status_ff))
    else $error("literal load wrong");

endmodule

// File: hdl/mid_pkg.sv
/*
  shared constants for the instruction decode and execute core:
  word layout, opcode patterns, flag positions, register offsets and reset values.
  assumes nothing of its surroundings; imported whole by the core module.
*/
package mid_pkg;

  // word and field widths
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned TGT_W   = 10;

  // status bit positions
  localparam int unsigned FLAG_C  = 0;
  localparam int unsigned FLAG_DC = 1;
  localparam int unsigned FLAG_Z  = 2;
  localparam int unsigned FLAG_PD = 3;
  localparam int unsigned FLAG_TO = 4;
  localparam int unsigned STAT_W  = 5;

  // register port offsets
  localparam logic [2:0] REG_STATUS = 3'h0;
  localparam logic [2:0] REG_ACC    = 3'h1;
  localparam logic [2:0] REG_PTR_LO = 3'h2;
  localparam logic [2:0] REG_PTR_HI = 3'h3;

  // reset values
  localparam logic [4:0] STATUS_RST = 5'h18;
  localparam logic [7:0] ACC_RST    = 8'h00;

  // whole-word encodings
  localparam logic [13:0] W_NOP    = 14'h0000;
  localparam logic [13:0] W_SLEEP  = 14'h0003;
  localparam logic [13:0] W_DOGCLR = 14'h0004;
  localparam logic [13:0] W_RET    = 14'h0040;
  localparam logic [13:0] W_INTERRUPT_EXIT   = 14'h0060;
  localparam logic [13:0] W_CLRACC = 14'h0140;

  // upper six bits of byte and literal operations
  localparam logic [5:0] P_SUB  = 6'h02;
  localparam logic [5:0] P_DEC  = 6'h03;
  localparam logic [5:0] P_OR   = 6'h04;
  localparam logic [5:0] P_AND  = 6'h05;
  localparam logic [5:0] P_XOR  = 6'h06;
  localparam logic [5:0] P_ADD  = 6'h07;
  localparam logic [5:0] P_COM  = 6'h09;
  localparam logic [5:0] P_INC  = 6'h0a;
  localparam logic [5:0] P_DECS = 6'h0b;
  localparam logic [5:0] P_RRC  = 6'h0c;
  localparam logic [5:0] P_RLC  = 6'h0d;
  localparam logic [5:0] P_SWAP = 6'h0e;
  localparam logic [5:0] P_INCS = 6'h0f;
  localparam logic [5:0] P_RETL = 6'h18;
  localparam logic [5:0] P_LDL  = 6'h19;
  localparam logic [5:0] P_ORL  = 6'h1a;
  localparam logic [5:0] P_ANDL = 6'h1b;
  localparam logic [5:0] P_ADDL = 6'h1c;
  localparam logic [5:0] P_XORL = 6'h1f;

  // upper seven bits of single-form byte operations
  localparam logic [6:0] P_STORE = 7'h01;
  localparam logic [6:0] P_CLEAR_REG  = 7'h03;
  localparam logic [6:0] P_LOAD  = 7'h10;
  localparam logic [6:0] P_REG_NULL_TEST = 7'h11;

  // upper five bits of bit operations
  localparam logic [4:0] P_BCLR = 5'h08;
  localparam logic [4:0] P_BSET = 5'h09;
  localparam logic [4:0] P_BTSC = 5'h0a;
  localparam logic [4:0] P_BTSS = 5'h0b;

  // upper four bits of branch operations
  localparam logic [3:0] P_CALL = 4'h8;
  localparam logic [3:0] P_JUMP = 4'hc;

  typedef enum logic [5:0] {
    OP_NOP, OP_ADD, OP_SUB, OP_AND, OP_OR, OP_XOR, OP_CLEAR_REG, OP_CLEAR_ACC, OP_COM,
    OP_DEC, OP_INC, OP_DECS, OP_INCS, OP_LOAD, OP_STORE, OP_STORER, OP_RLC,
    OP_RRC, OP_SWAP, OP_REG_NULL_TEST, OP_BCLR, OP_BSET, OP_BTSC, OP_BTSS, OP_ADDL,
    OP_ANDL, OP_ORL, OP_XORL, OP_LDL, OP_CALL, OP_JUMP, OP_RET, OP_INTERRUPT_EXIT,
    OP_RETL, OP_DOGCLR, OP_SLEEP
  } mid_op_t;

  typedef enum logic [4:0] {
    ST_FETCH = 5'b00001,
    ST_EXEC  = 5'b00010,
    ST_DUMA  = 5'b00100,
    ST_DUMB  = 5'b01000,
    ST_SLEEP = 5'b10000
  } mid_state_t;

endpackage

// File: tb/mid_mem_model.sv
/*
  program memory, register file and stack beside the decode core.
  assumes the core samples words and read data in the clock they appear.
*/
`timescale 1ns/10ps
module mid_mem_model (
  input  wire logic        mclk_in,
  input  wire logic        fetch_in,
  input  wire logic [9:0]  ptr_in,
  output logic      [13:0] instr_out,
  input  wire logic [6:0]  addr_in,
  input  wire logic        rplane_in,
  input  wire logic        wr_in,
  input  wire logic [7:0]  wdata_in,
  output logic      [7:0]  rdata_out,
  input  wire logic        push_in,
  input  wire logic        pop_in,
  input  wire logic [9:0]  push_data_in,
  output logic      [9:0]  head_out
);
  logic [13:0] rom [1024];
  logic [7:0]  rf  [128];
  logic [7:0]  rp  [64];
  logic [9:0]  stk [8];
  logic [2:0]  sp;
  // word only in the fetch clock, its bitwise inverse otherwise
  assign instr_out = fetch_in ? rom[ptr_in] : ~rom[ptr_in];
  assign rdata_out = rf[addr_in];
  assign head_out  = stk[sp - 3'h1];
  // register writes and stack moves
  always @(posedge mclk_in)
  begin
    if (wr_in && rplane_in) rp[addr_in[5:0]] <= wdata_in;
    if (wr_in && !rplane_in) rf[addr_in] <= wdata_in;
    if (push_in) stk[sp] <= push_data_in;
    if (push_in) sp <= sp + 3'h1;
    if (pop_in) sp <= sp - 3'h1;
  end
endmodule

// File: tb/testbench.sv
/*
  testbench for the decode core: short programs run from reset,
  results judged through the register port and the memory model.
*/
`timescale 1ns/10ps
module testbench
  import mid_pkg::*;
;
  logic       mclk_in = 1'b0;
  logic       arst_n_in = 1'b0;
  logic       wake_in = 1'b0;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [2:0] reg_addr_in = 3'h0;
  logic [7:0] reg_wdata_in = 8'h00;
  logic       fetch, rpl, rfwr, push, pop, sb, done;
  logic [9:0] ptr, pdat, head;
  logic [13:0] instr;
  logic [6:0] rfa;
  logic [7:0] rfrd, rfwd, rdata, v;
  logic       dclr, gie;
  logic [1:0] cyc;
  int         bad_count = 0;
  int         checks = 0;
  int         done_cnt = 0;
  int         dog_cnt = 0;
  int         gie_cnt = 0;
  int         cyc_sum = 0;

  always #10 mclk_in = ~mclk_in;
  // count executed words, their cycles and side pulses where they are settled
  always @(negedge mclk_in)
  begin
    if (done === 1'b1) done_cnt++;
    if (done === 1'b1) cyc_sum += cyc;
    if (dclr === 1'b1) dog_cnt++;
    if (gie === 1'b1) gie_cnt++;
  end

  mid_core #(.PTR_W(10)) i_dut (.mclk_in(mclk_in), .arst_n_in(arst_n_in), .instr_in(instr),
    .fetch_out(fetch), .fetch_pointer_out(ptr), .rf_addr_out(rfa), .rf_rplane_out(rpl),
    .rf_rdata_in(rfrd), .rf_wr_out(rfwr), .rf_wdata_out(rfwd), .stack_push_out(push),
    .stack_pop_out(pop), .stack_push_data_out(pdat), .stack_head_in(head),
    .dog_clear_out(dclr), .gie_set_out(gie), .standby_out(sb), .wake_in(wake_in),
    .instr_done_out(done), .instr_cycles_out(cyc), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(rdata));

  mid_mem_model i_mem (.mclk_in(mclk_in), .fetch_in(fetch), .ptr_in(ptr), .instr_out(instr),
    .addr_in(rfa), .rplane_in(rpl), .wr_in(rfwr), .wdata_in(rfwd), .rdata_out(rfrd),
    .push_in(push), .pop_in(pop), .push_data_in(pdat), .head_out(head));

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    reg_rd_in   <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in    <= 1'b1;
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask

  // hold reset, blank memory and stack
  task automatic prep();
    arst_n_in <= 1'b0;
    foreach (i_mem.rom[i]) i_mem.rom[i] = 14'h0000;
    i_mem.sp = 3'h0;
    done_cnt = 0;
    dog_cnt = 0;
    gie_cnt = 0;
    cyc_sum = 0;
  endtask

  // release reset and wait for n executed words
  task automatic go(input int n);
    int i;
    repeat (8) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    for (i = 0; i < 400 && done_cnt < n; i++) @(posedge mclk_in);
    if (done_cnt < n) bad_count++;
    if (done_cnt < n) tally_and_finish();
  endtask

  task automatic s_add();
    prep();
    i_mem.rf[16] = 8'hc2;
    i_mem.rom[0] = {P_LDL, 8'h17};
    i_mem.rom[1] = {P_ADD, 1'b0, 7'h10};
    i_mem.rom[2] = {P_ADD, 1'b1, 7'h10};
    go(3);
    rd(REG_ACC, v);
    chk("acc", 16'h00d9, {8'h00, v});
    chk("reg", 16'h009b, {8'h00, i_mem.rf[16]});
    rd(REG_STATUS, v);
    chk("status", 16'h0019, {8'h00, v});
  endtask

  task automatic s_logic();
    prep();
    i_mem.rf[17] = 8'h5a;
    i_mem.rom[0] = {P_LDL, 8'ha3};
    i_mem.rom[1] = {P_ANDL, 8'h5f};
    i_mem.rom[2] = {P_CLEAR_REG, 7'h11};
    i_mem.rom[3] = {P_LDL, 8'h44};
    go(4);
    rd(REG_ACC, v);
    chk("acc", 16'h0044, {8'h00, v});
    chk("reg", 16'h0000, {8'h00, i_mem.rf[17]});
    rd(REG_STATUS, v);
    chk("status", 16'h001c, {8'h00, v});
  endtask

  task automatic s_skip();
    prep();
    i_mem.rf[18] = 8'h01;
    i_mem.rom[0] = {P_DECS, 1'b1, 7'h12};
    i_mem.rom[1] = {P_ADDL, 8'h55};
    i_mem.rom[2] = {P_ADDL, 8'h01};
    go(2);
    rd(REG_ACC, v);
    chk("acc", 16'h0001, {8'h00, v});
    chk("reg", 16'h0000, {8'h00, i_mem.rf[18]});
  endtask

  task automatic s_call();
    prep();
    i_mem.rom[0] = {P_CALL, 10'h005};
    i_mem.rom[5] = {P_LDL, 8'h3c};
    go(2);
    rd(REG_ACC, v);
    chk("acc", 16'h003c, {8'h00, v});
    chk("stack", 16'h0001, {6'h00, i_mem.stk[0]});
  endtask

  // bit ops, skip, two successive calls and returns, dog clear, cycle counts
  task automatic s_bits();
    prep();
    i_mem.rf[20] = 8'hc7;
    i_mem.rom[0]  = {P_BCLR, 3'h7, 6'h14};
    i_mem.rom[1]  = {P_BSET, 3'h3, 6'h14};
    i_mem.rom[2]  = {P_BTSS, 3'h3, 6'h14};
    i_mem.rom[3]  = {P_LDL, 8'hff};
    i_mem.rom[4]  = {P_CALL, 10'h00a};
    i_mem.rom[5]  = {P_SUB, 1'b1, 7'h14};
    i_mem.rom[6]  = W_DOGCLR;
    i_mem.rom[7]  = {P_CALL, 10'h00c};
    i_mem.rom[8]  = {P_JUMP, 10'h008};
    i_mem.rom[10] = {P_RETL, 8'h3a};
    i_mem.rom[12] = W_INTERRUPT_EXIT;
    go(10);
    chk("cycles", 16'h0010, 16'(cyc_sum));
    chk("dog", 16'h0001, 16'(dog_cnt));
    chk("gie", 16'h0001, 16'(gie_cnt));
    chk("sp", 16'h0000, {13'h0000, i_mem.sp});
    chk("stack", 16'h0008, {6'h00, i_mem.stk[0]});
    chk("reg", 16'h0015, {8'h00, i_mem.rf[20]});
    rd(REG_ACC, v);
    chk("acc", 16'h003a, {8'h00, v});
    rd(REG_STATUS, v);
    chk("status", 16'h001b, {8'h00, v});
  endtask

  task automatic s_sleep();
    int i;
    prep();
    i_mem.rom[0] = W_SLEEP;
    go(1);
    for (i = 0; i < 20 && sb !== 1'b1; i++) @(posedge mclk_in);
    chk("standby", 16'h0001, {15'h0000, sb});
    wr(REG_ACC, 8'h5e);
    wr(3'h6, 8'hff);
    rd(REG_ACC, v);
    chk("acc", 16'h005e, {8'h00, v});
    rd(3'h6, v);
    chk("unmapped", 16'h0000, {8'h00, v});
    rd(REG_STATUS, v);
    chk("status", 16'h0010, {8'h00, v});
    rd(REG_PTR_LO, v);
    chk("ptr_lo", 16'h0001, {8'h00, v});
    rd(REG_PTR_HI, v);
    chk("ptr_hi", 16'h0000, {8'h00, v});
    wake_in <= 1'b1;
    for (i = 0; i < 20 && sb !== 1'b0; i++) @(posedge mclk_in);
    wake_in <= 1'b0;
    chk("woken", 16'h0000, {15'h0000, sb});
  endtask

  initial
  begin
    s_add();
    s_logic();
    s_skip();
    s_call();
    s_bits();
    s_sleep();
    tally_and_finish();
  end
endmodule
